// file: logic/ccu_pair.sv
// Two capture/compare/PWM units behind an APB slave.
// Assumes external Timer1, Timer2 and A/D logic on this clock.
`timescale 1ns/1ps
`default_nettype none
module ccu_pair
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic              pready,
    output var  logic [31:0]       prdata,
    output var  logic              pslverr,
    // Timer1 time base
    input  wire logic [15:0]       t1_count,
    output var  logic              timebase1_clear,
    // Timer2 time base
    input  wire logic              pwm_period_tick,
    input  wire logic [9:0]        pwm_count,
    // A/D converter
    input  wire logic              ad_enable,
    output var  logic              ad_start,
    // Unit pins
    input  wire logic [1:0]        pin_in,
    output var  logic [1:0]        pin_out,
    // Interrupt
    output var  logic              irq
);

    // -----------------------------------------------------------------
    // Elaboration check
    // -----------------------------------------------------------------
    if (ADDR_W < 8)
    begin : g_addr_check
        $error("ADDR_W must be at least 8");
    end

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    logic              setup;
    logic              wr;
    logic              hit;
    logic [31:0]       rd_mux;
    logic [1:0]        sel_ctrl;
    logic [1:0]        sel_vl;
    logic [1:0]        sel_vh;
    logic              sel_stat;
    logic              sel_mask;
    logic [5:0]        ctrl [2];
    logic [15:0]       value [2];
    ccu_pkg::ccu_evt_s evt [2];
    logic [1:0]        irq_stat;
    logic [1:0]        irq_mask;
    logic [1:0]        next_stat;
    logic [1:0]        flags;

    function automatic logic at_index(input logic [7:0] idx);
        logic [ADDR_W-1:0] addr;
        addr = ADDR_W'({idx, 2'b00});
        return paddr == addr;
    endfunction

    // -----------------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------------
    assign setup = psel & ~penable;

    // Write lands only at the access edge with pready
    assign wr = psel & penable & pready & pwrite;

    always_comb
    begin
        sel_ctrl[0] = at_index(ccu_pkg::IDX_CTRL1);
        sel_ctrl[1] = at_index(ccu_pkg::IDX_CTRL2);
        sel_vl[0]   = at_index(ccu_pkg::IDX_VAL1L);
        sel_vl[1]   = at_index(ccu_pkg::IDX_VAL2L);
        sel_vh[0]   = at_index(ccu_pkg::IDX_VAL1H);
        sel_vh[1]   = at_index(ccu_pkg::IDX_VAL2H);
        sel_stat    = at_index(ccu_pkg::IDX_STAT);
        sel_mask    = at_index(ccu_pkg::IDX_MASK);
    end

    assign hit = (|sel_ctrl) | (|sel_vl) | (|sel_vh) | sel_stat | sel_mask;

    // -----------------------------------------------------------------
    // Read data
    // -----------------------------------------------------------------
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        // bits 7 and 6 stay zero
        if (sel_ctrl[0])
            rd_mux[5:0] = ctrl[0];
        else if (sel_ctrl[1])
            rd_mux[5:0] = ctrl[1];
        else if (sel_vl[0])
            rd_mux[7:0] = value[0][7:0];
        else if (sel_vl[1])
            rd_mux[7:0] = value[1][7:0];
        else if (sel_vh[0])
            rd_mux[7:0] = value[0][15:8];
        else if (sel_vh[1])
            rd_mux[7:0] = value[1][15:8];
        else if (sel_stat)
            rd_mux[1:0] = irq_stat;
        else if (sel_mask)
            rd_mux[1:0] = irq_mask;
    end

    // -----------------------------------------------------------------
    // APB answer
    // -----------------------------------------------------------------
    // One access cycle, no wait states
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            pready <= 1'b0;
        else
            pready <= setup;
    end

    // Sampled in setup; a capture in the access cycle shows next read
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata <= rd_mux;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            pslverr <= 1'b0;
        else
            pslverr <= setup & ~hit;
    end

    // -----------------------------------------------------------------
    // Control registers
    // -----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            ctrl[0] <= ccu_pkg::CTRL_RST;
            ctrl[1] <= ccu_pkg::CTRL_RST;
        end
        else
        begin
            if (wr && sel_ctrl[0])
                ctrl[0] <= pwdata[5:0];
            if (wr && sel_ctrl[1])
                ctrl[1] <= pwdata[5:0];
        end
    end

    // -----------------------------------------------------------------
    // Units
    // -----------------------------------------------------------------
    // both units see one Timer1 count and one Timer2
    for (genvar i = 0; i < 2; i++)
    begin : g_unit
        ccu_unit
        #(
            .HAS_AD      (i == 1)
        )
        u_unit
        (
            .clock       (clock),
            .rst_b       (rst_b),
            .ctrl        (ctrl[i]),
            .wr_low      (wr & sel_vl[i]),
            .wr_high     (wr & sel_vh[i]),
            .wdata       (pwdata[7:0]),
            .value       (value[i]),
            .t1_count    (t1_count),
            .period_tick (pwm_period_tick),
            .pwm_count   (pwm_count),
            .ad_enable   (ad_enable),
            .pin_in      (pin_in[i]),
            .pin_out     (pin_out[i]),
            .evt         (evt[i])
        );
        assign flags[i] = evt[i].flag;
    end

    // -----------------------------------------------------------------
    // Special event trigger
    // -----------------------------------------------------------------
    // either trigger clears the count
    // separate clear strobe, timer raises no overflow flag on it
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            timebase1_clear <= 1'b0;
        else
            timebase1_clear <= evt[0].trig | evt[1].trig;
    end

    // converter start from unit 2 only
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            ad_start <= 1'b0;
        else
            ad_start <= evt[1].ad;
    end

    // -----------------------------------------------------------------
    // Interrupt status and mask
    // -----------------------------------------------------------------
    // A new flag beats a write-one clear in the same cycle
    always_comb
    begin
        next_stat = irq_stat;
        if (wr && sel_stat)
            next_stat = irq_stat & ~pwdata[1:0];
        next_stat = next_stat | flags;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            irq_stat <= ccu_pkg::IRQ_RST;
        else
            irq_stat <= next_stat;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            irq_mask <= ccu_pkg::IRQ_RST;
        else if (wr && sel_mask)
            irq_mask <= pwdata[1:0];
    end

    // Registered from next values so it tracks status with no lag
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            irq <= 1'b0;
        else if (wr && sel_mask)
            irq <= |(next_stat & pwdata[1:0]);
        else
            irq <= |(next_stat & irq_mask);
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    irq_level_a:
        assert property (irq == |(irq_stat & irq_mask))
        else $error("interrupt does not follow status");
    ctrl_read_a:
        assert property (setup && !pwrite && (|sel_ctrl) |=> prdata[7:6] == 2'h0)
        else $error("control upper bits not zero");
    t1_clear_a:
        assert property (evt[0].trig |=> timebase1_clear)
        else $error("trigger did not clear timer");
    flag_sticky_a:
        assert property (evt[1].flag |=> irq_stat[1] ##1 irq_stat[1] || $past(wr))
        else $error("match flag not held");

endmodule // ccu_pair
`default_nettype wire

// file: logic/ccu_unit.sv
// One capture/compare/PWM unit with its 16-bit value register.
// Assumes timer counts and pin are synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module ccu_unit
#(
    parameter bit HAS_AD = 1'b0
)
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // Register side
    input  wire logic [5:0]        ctrl,
    input  wire logic              wr_low,
    input  wire logic              wr_high,
    input  wire logic [7:0]        wdata,
    output var  logic [15:0]       value,
    // Timers, converter and pin
    input  wire logic [15:0]       t1_count,
    input  wire logic              period_tick,
    input  wire logic [9:0]        pwm_count,
    input  wire logic              ad_enable,
    input  wire logic              pin_in,
    output var  logic              pin_out,
    output var  ccu_pkg::ccu_evt_s evt
);
    logic [3:0] mode;
    logic       off, cap, cmp, pwm, rise, fall, cap_edge, hit, match;
    logic       pin_prev, hit_prev;
    logic [3:0] presc;
    logic [1:0] lsb_latch;
    logic [9:0] duty;

    assign mode = ctrl[3:0];
    assign off  = (mode == ccu_pkg::MODE_OFF);
    assign cap  = (mode[3:2] == 2'h1);
    assign cmp  = (mode[3:2] == 2'h2);
    assign pwm  = (mode[3:2] == 2'h3);
    assign rise = pin_in & ~pin_prev;
    assign fall = ~pin_in & pin_prev;
    // equal count, one event per match
    assign hit   = (t1_count == value);
    assign match = cmp & hit & ~hit_prev;
    assign duty  = {value[15:8], lsb_latch};

    always_comb
    begin
        case (mode)
            ccu_pkg::CAP_FALL:   cap_edge = fall;
            ccu_pkg::CAP_RISE:   cap_edge = rise;
            ccu_pkg::CAP_RISE4:  cap_edge = rise & (presc[1:0] == ccu_pkg::PRESC_4);
            ccu_pkg::CAP_RISE16: cap_edge = rise & (presc == ccu_pkg::PRESC_16);
            default:             cap_edge = 1'b0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            pin_prev <= 1'b0;
        else
            pin_prev <= pin_in;
    end

    // off clears prescaler, match history and latches
    always_ff @(posedge clock)
    begin
        if (!rst_b || !cap)
            presc <= 4'h0;
        else if (rise)
            presc <= presc + 4'h1;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b || off)
            hit_prev <= 1'b0;
        else
            hit_prev <= hit;
    end

    // capture has priority over a software write
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            value <= ccu_pkg::VAL_RST;
        else if (cap_edge)
            value <= t1_count;
        else
        begin
            if (wr_low)
                value[7:0] <= wdata;
            // High byte is the read-only slave copy in PWM
            if (wr_high && !pwm)
                value[15:8] <= wdata;
            else if (pwm && period_tick)
                value[15:8] <= value[7:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b || off)
            lsb_latch <= 2'h0;
        else if (pwm && period_tick)
            lsb_latch <= ctrl[ccu_pkg::DUTY_LSB +: 2];
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b || off)
            pin_out <= 1'b0;
        else if (pwm)
        begin
            // rise on the shared period tick
            if (period_tick)
                pin_out <= ({value[7:0], ctrl[ccu_pkg::DUTY_LSB +: 2]} != 10'h000);
            else if (pwm_count >= duty)
                pin_out <= 1'b0;
        end
        else if (match && mode == ccu_pkg::CMP_SET)
            pin_out <= 1'b1;
        else if (match && mode == ccu_pkg::CMP_CLR)
            pin_out <= 1'b0;
    end

    // only the converter start differs per unit
    always_ff @(posedge clock)
    begin
        if (!rst_b || off)
            evt <= '0;
        else
        begin
            evt.flag <= cap_edge | match;
            evt.trig <= match & (mode == ccu_pkg::CMP_TRIG);
            evt.ad   <= match & (mode == ccu_pkg::CMP_TRIG) & HAS_AD & ad_enable;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    cap_copy_a:
        assert property (cap_edge |=> value == $past(t1_count) && evt.flag)
        else $error("capture did not copy timer");
    trig_mode_a:
        assert property (evt.trig |-> $past(mode) == ccu_pkg::CMP_TRIG)
        else $error("trigger outside trigger mode");
    off_quiet_a:
        assert property (off |=> !pin_out && evt == '0)
        else $error("disabled unit still active");
    soft_pin_a:
        assert property (mode == ccu_pkg::CMP_SOFT ##1 mode == ccu_pkg::CMP_SOFT
                         |-> $stable(pin_out))
        else $error("software mode moved pin");
    ad_gate_a:
        assert property (evt.ad |-> evt.trig && $past(ad_enable) && HAS_AD)
        else $error("converter start without trigger");
    pwm_rise_a:
        assert property (pwm && period_tick |=> pin_out == (duty != 10'h000))
        else $error("pwm edge not on period tick");

endmodule // ccu_unit
`default_nettype wire

// file: pkg/ccu_pkg.sv
// Constants and types for the capture/compare/PWM pair.
// Assumes an APB master and external Timer1, Timer2 and A/D logic.
//
// How it works
// - each unit holds one 16-bit capture, compare or duty value.
// - the value is reached as separate low and high bytes.
// - both units act alike except the special event trigger action.
// - unit 1 trigger clears the whole Timer1 count.
// - unit 2 trigger clears Timer1 and starts A/D when enabled.
// - capture/compare use shared Timer1; PWM uses Timer2.
// - both PWMs share period tick; rising edges aligned.
// - duty is low byte as eight MSBs plus two control LSBs.
// - control bits 7 and 6 read as zero.
// - mode 0000 disables the unit and resets its state.
// - 0100 falling, 0101 rising, 0110 every fourth rising edge capture.
// - duty LSB bits do nothing in capture or compare modes.
// - 0111 captures every sixteenth rise; 1000 sets pin and flag on match.
// - 1010 flag only; 1011 flag plus trigger; pin untouched.
// - trigger clear of Timer1 never sets the overflow flag.
package ccu_pkg;

    // -----------------------------------------------------------------
    // Register indices, byte address is four times the index
    // -----------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL1 = 8'h17;
    localparam logic [7:0] IDX_CTRL2 = 8'h1d;
    localparam logic [7:0] IDX_VAL1L = 8'h15;
    localparam logic [7:0] IDX_VAL1H = 8'h16;
    localparam logic [7:0] IDX_VAL2L = 8'h1b;
    localparam logic [7:0] IDX_VAL2H = 8'h1c;
    localparam logic [7:0] IDX_STAT  = 8'h20;
    localparam logic [7:0] IDX_MASK  = 8'h21;

    // -----------------------------------------------------------------
    // Fields and reset values
    // -----------------------------------------------------------------
    localparam int         DUTY_LSB  = 4;
    localparam logic [5:0] CTRL_RST  = 6'h00;
    localparam logic [15:0] VAL_RST  = 16'h0000;
    localparam logic [1:0] IRQ_RST   = 2'h0;
    localparam logic [1:0] PRESC_4   = 2'h3;
    localparam logic [3:0] PRESC_16  = 4'hf;

    typedef enum logic [3:0] {
        MODE_OFF   = 4'h0,
        CAP_FALL   = 4'h4,
        CAP_RISE   = 4'h5,
        CAP_RISE4  = 4'h6,
        CAP_RISE16 = 4'h7,
        CMP_SET    = 4'h8,
        CMP_CLR    = 4'h9,
        CMP_SOFT   = 4'ha,
        CMP_TRIG   = 4'hb
    } ccu_mode_e;

    typedef struct packed {
        logic flag;
        logic trig;
        logic ad;
    } ccu_evt_s;

endpackage

// file: test/ccu_far_model.sv
// Behavioural Timer1, Timer2 and A/D converter facing the unit pair.
// Assumes the bench drives run, load and load_val just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module ccu_far_model
#(
    parameter int PERIOD = 64
)
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Bench control of Timer1
    input  wire logic        run,
    input  wire logic        load,
    input  wire logic [15:0] load_val,
    // Timer1 time base
    input  wire logic        clear,
    output var  logic [15:0] t1_count,
    output var  logic        t1_overflow,
    // Timer2 time base
    output var  logic        period_tick,
    output var  logic [9:0]  pwm_count,
    // A/D converter
    input  wire logic        ad_start,
    output var  int          ad_count
);
    // -----------------------------------------------------------------
    // Timer1
    // -----------------------------------------------------------------
    // shared count, trigger clear
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            t1_count    <= 16'h0000;
            t1_overflow <= 1'b0;
        end
        else if (clear)
            t1_count <= 16'h0000;
        else if (load)
            t1_count <= load_val;
        else if (run)
        begin
            t1_count <= t1_count + 16'h0001;
            // Only a real wrap flags overflow
            if (t1_count == 16'hffff)
                t1_overflow <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // Timer2 and converter
    // -----------------------------------------------------------------
    // one period tick for both
    always_ff @(posedge clock)
    begin
        if (!rst_b || pwm_count == 10'(PERIOD - 1))
            pwm_count <= 10'h000;
        else
            pwm_count <= pwm_count + 10'h001;
    end
    assign period_tick = (pwm_count == 10'(PERIOD - 1));

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            ad_count <= 0;
        else if (ad_start)
            ad_count <= ad_count + 1;
    end
endmodule // ccu_far_model
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the unit pair over APB.
// Assumes the far-side model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {logic [7:0] idx; logic [7:0] w; logic [7:0] e;} ccu_row_s;
    logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, irq;
    logic        tbc, tick, ad_enable, ad_start, run, load, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] t1_count, load_val, v;
    logic [9:0]  pwm_count;
    logic [1:0]  pin_in, pin_out;
    logic [7:0]  ci, li, hi;
    int          fail_count, n_tests, cycles, n, nedge, a0, h0, h1;
    ccu_row_s    rows [8];

    ccu_pair u_dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .t1_count(t1_count), .timebase1_clear(tbc),
        .pwm_period_tick(tick), .pwm_count(pwm_count), .ad_enable(ad_enable),
        .ad_start(ad_start), .pin_in(pin_in), .pin_out(pin_out), .irq(irq));
    ccu_far_model u_far (.clock(clock), .rst_b(rst_b), .run(run), .load(load),
        .load_val(load_val), .clear(tbc), .t1_count(t1_count), .t1_overflow(),
        .period_tick(tick), .pwm_count(pwm_count), .ad_start(ad_start), .ad_count(a0));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Held until pready is sampled high; byte address is four times the index
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int k;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx[5:0], 2'b00};
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(name, rd, exp);
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clock);
    endtask

    task automatic t1set(input logic [15:0] val);
        @(posedge clock);
        load     <= 1'b1;
        load_val <= val;
        @(posedge clock);
        load <= 1'b0;
    endtask

    // Timer1 is loaded before each pin change so the capturing edge shows it
    task automatic pulse(input int u, input logic [15:0] vr, input logic [15:0] vf);
        t1set(vr);
        pin_in[u] <= 1'b1;
        idle(2);
        t1set(vf);
        pin_in[u] <= 1'b0;
        idle(2);
    endtask

    function automatic logic sig(input int sel, input int u);
        return (sel == 0) ? pin_out[u] : (sel == 1) ? irq : tbc;
    endfunction

    task automatic wait_on(input int sel, input int u);
        n = 0;
        while (sig(sel, u) !== 1'b1 && n < 400)
        begin
            @(posedge clock);
            n++;
        end
        check("wait", {31'h0, sig(sel, u)}, 32'h1);
    endtask

    function automatic logic [31:0] inr(input int x, input int lo, input int hi_b);
        return {31'h0, x >= lo && x <= hi_b};
    endfunction

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fail_count++;
            finish_test();
        end
    end

    initial
    begin
        {rst_b, psel, penable, pwrite, ad_enable, run, load} = 7'h00;
        {paddr, pwdata, load_val, pin_in} = 58'h0;
        rows = '{'{ccu_pkg::IDX_CTRL1, 8'hf0, 8'h30}, '{ccu_pkg::IDX_CTRL2, 8'hc5, 8'h05},
                 '{ccu_pkg::IDX_VAL1L, 8'ha5, 8'ha5}, '{ccu_pkg::IDX_VAL1H, 8'h5a, 8'h5a},
                 '{ccu_pkg::IDX_VAL2L, 8'h3c, 8'h3c}, '{ccu_pkg::IDX_VAL2H, 8'hc3, 8'hc3},
                 '{ccu_pkg::IDX_STAT, 8'h03, 8'h00}, '{ccu_pkg::IDX_MASK, 8'h03, 8'h03}};
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        foreach (rows[i])
            rdchk("reset value", rows[i].idx, 32'h0);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].idx, {24'h0, rows[i].w});
            rdchk("readback", rows[i].idx, {24'h0, rows[i].e});
        end
        apb(1'b0, 8'h00, 32'h0);
        check("unmapped read", {rd[30:0], err}, 32'h1);
        // Capture modes on both units, duty bits set to show they are ignored
        for (int u = 0; u < 2; u++)
            for (int m = 0; m < 4; m++)
            begin
                ci = u ? ccu_pkg::IDX_CTRL2 : ccu_pkg::IDX_CTRL1;
                li = u ? ccu_pkg::IDX_VAL2L : ccu_pkg::IDX_VAL1L;
                hi = u ? ccu_pkg::IDX_VAL2H : ccu_pkg::IDX_VAL1H;
                nedge = (m == 2) ? 4 : (m == 3) ? 16 : 1;
                apb(1'b1, ci, 32'h0);
                apb(1'b1, li, 32'h0);
                apb(1'b1, hi, 32'h0);
                apb(1'b1, ccu_pkg::IDX_STAT, 32'h3);
                apb(1'b1, ccu_pkg::IDX_MASK, 32'h0);
                apb(1'b1, ci, {26'h0, 2'b11, 4'(4 + m)});
                for (int k = 0; k < nedge; k++)
                begin
                    if (k == nedge - 1 && nedge > 1)
                        rdchk("early status", ccu_pkg::IDX_STAT, 32'h0);
                    pulse(u, 16'(16'h1200 + 16'(k)), 16'hf0f0);
                end
                v = (m == 0) ? 16'hf0f0 : 16'(16'h1200 + 16'(nedge - 1));
                rdchk("value low", li, {24'h0, v[7:0]});
                rdchk("value high", hi, {24'h0, v[15:8]});
                rdchk("status", ccu_pkg::IDX_STAT, 32'(1 << u));
                check("masked irq", {31'h0, irq}, 32'h0);
                apb(1'b1, ccu_pkg::IDX_MASK, 32'h3);
                idle(2);
                check("irq", {31'h0, irq}, 32'h1);
                apb(1'b1, ccu_pkg::IDX_STAT, 32'(1 << u));
                idle(2);
                check("cleared irq", {31'h0, irq}, 32'h0);
            end
        // Compare: set pin, then flag only
        run <= 1'b1;
        for (int u = 0; u < 2; u++)
        begin
            ci = u ? ccu_pkg::IDX_CTRL2 : ccu_pkg::IDX_CTRL1;
            apb(1'b1, ci, 32'h0);
            apb(1'b1, u ? ccu_pkg::IDX_VAL2L : ccu_pkg::IDX_VAL1L, 32'h40);
            apb(1'b1, u ? ccu_pkg::IDX_VAL2H : ccu_pkg::IDX_VAL1H, 32'h0);
            t1set(16'h0000);
            apb(1'b1, ci, 32'h38);
            wait_on(0, u);
            check("match count", inr(t1_count, 16'h41, 16'h43), 32'h1);
            idle(2);
            check("set flag", {31'h0, irq}, 32'h1);
            apb(1'b1, ci, 32'h0);
            idle(2);
            check("pin after off", {30'h0, pin_out}, 32'h0);
            apb(1'b1, ccu_pkg::IDX_STAT, 32'h3);
            t1set(16'h0000);
            apb(1'b1, ci, 32'h0a);
            wait_on(1, u);
            check("soft pin", {30'h0, pin_out}, 32'h0);
            apb(1'b1, ci, 32'h0);
            apb(1'b1, ccu_pkg::IDX_STAT, 32'h3);
        end
        // Special event trigger: unit 1, unit 2 with and without converter
        for (int c = 0; c < 3; c++)
        begin
            ci = c ? ccu_pkg::IDX_CTRL2 : ccu_pkg::IDX_CTRL1;
            ad_enable <= (c != 2);
            h0 = a0;
            t1set(16'h0000);
            apb(1'b1, ci, 32'h0b);
            wait_on(2, 0);
            check("pin in trigger", {30'h0, pin_out}, 32'h0);
            @(posedge clock);
            wait_on(2, 0);
            check("trigger period", inr(n + 1, 16'h41, 16'h44), 32'h1);
            idle(2);
            check("conversions", 32'(a0 - h0), (c == 1) ? 32'h2 : 32'h0);
            rdchk("trigger flag", ccu_pkg::IDX_STAT, c ? 32'h2 : 32'h1);
            apb(1'b1, ci, 32'h0);
            apb(1'b1, ccu_pkg::IDX_STAT, 32'h3);
        end
        // PWM on both units: duty 16 and {08, 10} = 34, mode codes 1100 and 1111
        apb(1'b1, ccu_pkg::IDX_VAL1L, 32'h04);
        apb(1'b1, ccu_pkg::IDX_VAL2L, 32'h08);
        // Unit 2 first, so unit 1 first rises on a tick both see
        apb(1'b1, ccu_pkg::IDX_CTRL2, 32'h2f);
        apb(1'b1, ccu_pkg::IDX_CTRL1, 32'h0c);
        wait_on(0, 0);
        check("aligned rise", {31'h0, pin_out[1]}, 32'h1);
        h0 = 0;
        h1 = 0;
        repeat (60)
        begin
            h0 += int'(pin_out[0]);
            h1 += int'(pin_out[1]);
            @(posedge clock);
        end
        check("duty unit 1", inr(h0, 16, 18), 32'h1);
        check("duty unit 2", inr(h1, 34, 36), 32'h1);
        // Reset in mid-run while both units run PWM
        rst_b <= 1'b0;
        idle(2);
        rst_b <= 1'b1;
        check("reset pins", {30'h0, pin_out}, 32'h0);
        rdchk("reset control", ccu_pkg::IDX_CTRL2, 32'h0);
        finish_test();
    end
endmodule // tb
`default_nettype wire
